// ### priv_state_ctrl.sv
// Purpose: Supervisor and problem state control with the status word instructions.
// Assumes: The decoder holds an operation until op_ready; storage answers with mem_ack.
// Notes: Interrupt entry stores the old word and loads the new one over the storage port.
// Behaviour
// - Status word bit 15 is 0 in supervisor state and 1 in problem state.
// - A privileged operation in problem state is suppressed and raises a program check.
// - Every input/output instruction is privileged.
// - The word holds system mask, code, length, condition code, program mask, address.
// - The full load is privileged and replaces the whole word, state bit included.
// - A branch changes only the instruction address, never the state bit.
// - A supervisor call loads the new word from location 96, entering supervisor state.
// - Code and length fields change only on interrupts and full loads; address advances with execution.
// - Set system mask is privileged and replaces bits 0-7 with the new mask.
// - Set system mask uses the storage-immediate format and ignores the immediate byte.
// - Set program mask is not privileged and overwrites bits 34-39.
// - Set program mask uses the register format and ignores the second register.
// - Fixed or decimal overflow sets condition code 3; a zero mask bit blocks the trap.
// - Program mask bits gate four exceptions; every other exception always traps.
// - Masked input/output and external requests wait and are taken once unmasked.
`include "psc_map.svh"
`default_nettype none

module priv_state_ctrl
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Decoded operation
  input wire logic op_valid,
  input wire op_kind_e op_kind,
  input wire logic [1:0] op_ilc,
  input wire logic [31:0] op_r1_data,
  input wire logic [31:0] op_base_data,
  input wire logic [11:0] op_disp,
  input wire logic [23:0] op_branch_target,
  input wire logic [7:0] op_svc_code,
  input wire logic op_cc_wr,
  input wire logic [1:0] op_cc,
  input wire logic op_exc_valid,
  input wire logic [3:0] op_exc_code,
  output logic op_ready,
  output logic op_done,
  output logic op_suppressed,
  output logic io_start,
  // Input/output and external requests
  input wire logic [7:0] irq_pend,
  output logic irq_ack,
  output logic [2:0] irq_ack_index,
  output logic int_taken,
  // Storage port
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [63:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  // Status
  output logic [63:0] status_word,
  output logic problem_state
);
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [23:0] eff_addr(input logic [31:0] base, input logic [11:0] disp);
    eff_addr = base[23:0] + {12'h000, disp};
  endfunction

  function automatic logic [23:0] ia_next(input logic [23:0] ia, input logic [1:0] ilc);
    ia_next = ia + {21'h0, ilc, 1'b0};
  endfunction

  function automatic logic [7:0] byte_sel(input logic [63:0] dw, input logic [2:0] idx);
    byte_sel = dw[63 - 8 * idx -: 8];
  endfunction

  function automatic logic [2:0] chan_pick(input logic [7:0] v);
    chan_pick = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        chan_pick = 3'(7 - i);
      end
    end
  endfunction

  function automatic logic exc_enabled(input logic [3:0] code, input logic [3:0] pm);
    case (code)
      `XC_FIX_OVF: exc_enabled = pm[`PM_FIX_OVF];
      `XC_DEC_OVF: exc_enabled = pm[`PM_DEC_OVF];
      `XC_EXP_UND: exc_enabled = pm[`PM_EXP_UND];
      `XC_SIGNIF: exc_enabled = pm[`PM_SIGNIF];
      default: exc_enabled = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Status word register
  word_upd_if upd ();

  status_word_reg u_word (
    .mclk(mclk),
    .resetn(resetn),
    .upd(upd)
  );

  seq_state_e state_q, state_d;
  op_kind_e kind_q, kind_d;
  logic [23:0] addr_q, addr_d;
  logic [23:0] new_q, new_d;
  logic [23:0] ia_q, ia_d;
  logic [2:0] sel_q, sel_d;
  logic [1:0] ilc_last_q;
  logic irq_ack_q;
  logic [2:0] irq_idx_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [63:0] cur = upd.word;
  wire is_problem = cur[`PROB_BIT];
  wire [7:0] irq_live = irq_pend & cur[`SM_HI:`SM_LO];
  wire idle = (state_q == ST_IDLE);
  wire irq_go = idle && (|irq_live);
  wire accept = idle && !irq_go && op_valid;
  wire is_priv = (op_kind == OP_LOAD_STATUS) || (op_kind == OP_SET_SYS_MASK) ||
                 (op_kind == OP_IO) || (op_kind == OP_PRIV_OTHER);
  wire priv_trap = accept && is_priv && is_problem;
  wire exec = accept && !priv_trap;
  wire exc_hit = exec && (op_kind == OP_GENERAL) && op_exc_valid;
  wire exc_ovf = exc_hit && ((op_exc_code == `XC_FIX_OVF) || (op_exc_code == `XC_DEC_OVF));
  wire exc_take = exc_hit && exc_enabled(op_exc_code, cur[`PM_HI:`PM_LO]);
  wire svc_take = exec && (op_kind == OP_SVC);
  wire prog_take = priv_trap || exc_take;
  wire mem_op = exec && ((op_kind == OP_LOAD_STATUS) || (op_kind == OP_SET_SYS_MASK));
  wire [23:0] ea = eff_addr(op_base_data, op_disp);
  wire [23:0] ia_seq = ia_next(cur[`IA_HI:`IA_LO], op_ilc);
  wire [2:0] irq_chan = chan_pick(irq_live);
  wire irq_ext = (irq_chan == 3'h7);
  wire read_ack = (state_q == ST_READ_OP) && mem_ack;
  wire store_ack = (state_q == ST_STORE_OLD) && mem_ack;
  wire load_ack = (state_q == ST_LOAD_NEW) && mem_ack;

  ////////////////////////////////////////////////////////////////////////////////
  // Field updates
  assign upd.ld_all = load_ack || (read_ack && (kind_q == OP_LOAD_STATUS));
  assign upd.all_val = mem_rdata;
  // The immediate byte of the instruction never reaches this block
  assign upd.ld_sm = read_ack && (kind_q == OP_SET_SYS_MASK);
  assign upd.sm_val = byte_sel(mem_rdata, sel_q);
  // Second register field is not an input at all
  assign upd.ld_ccpm = exec && (op_kind == OP_SET_PROG_MASK);
  assign upd.ccpm_val = op_r1_data[29:24];
  assign upd.ld_cc = exec && (op_kind == OP_GENERAL) && (op_cc_wr || exc_ovf);
  assign upd.cc_val = exc_ovf ? `CC_OVERFLOW : op_cc;
  assign upd.ld_ia = (accept && !mem_op) || (read_ack && (kind_q == OP_SET_SYS_MASK));
  assign upd.ia_val = read_ack ? ia_q :
                      ((exec && (op_kind == OP_BRANCH)) ? op_branch_target : ia_seq);
  assign upd.ld_code = prog_take || svc_take || irq_go;
  assign upd.code_val = irq_go ? {13'h0, irq_chan} :
                        svc_take ? {8'h00, op_svc_code} :
                        priv_trap ? `XC_PRIV : {12'h000, op_exc_code};
  assign upd.ilc_val = irq_go ? ilc_last_q : op_ilc;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    addr_d = addr_q;
    new_d = new_q;
    ia_d = ia_q;
    sel_d = sel_q;
    case (state_q)
      ST_IDLE: begin
        if (irq_go) begin
          state_d = ST_STORE_OLD;
          kind_d = OP_NONE;
          addr_d = irq_ext ? `A_OLD_EXT : `A_OLD_IO;
          new_d = irq_ext ? `A_NEW_EXT : `A_NEW_IO;
        end else if (prog_take) begin
          state_d = ST_STORE_OLD;
          kind_d = op_kind;
          addr_d = `A_OLD_PROG;
          new_d = `A_NEW_PROG;
        end else if (svc_take) begin
          state_d = ST_STORE_OLD;
          kind_d = OP_SVC;
          addr_d = `A_OLD_SVC;
          new_d = `A_NEW_SVC;
        end else if (mem_op) begin
          state_d = ST_READ_OP;
          kind_d = op_kind;
          addr_d = {ea[23:3], 3'h0};
          sel_d = ea[2:0];
          ia_d = ia_seq;
        end
      end
      ST_READ_OP: begin
        if (mem_ack) begin
          state_d = ST_IDLE;
        end
      end
      ST_STORE_OLD: begin
        if (mem_ack) begin
          state_d = ST_LOAD_NEW;
          addr_d = new_q;
        end
      end
      ST_LOAD_NEW: begin
        if (mem_ack) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      kind_q <= OP_NONE;
      addr_q <= 24'h000000;
      new_q <= 24'h000000;
      ia_q <= 24'h000000;
      sel_q <= 3'h0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      new_q <= new_d;
      ia_q <= ia_d;
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ilc_last_q <= 2'h0;
      irq_ack_q <= 1'b0;
      irq_idx_q <= 3'h0;
    end else begin
      ilc_last_q <= accept ? op_ilc : ilc_last_q;
      irq_ack_q <= irq_go;
      irq_idx_q <= irq_go ? irq_chan : irq_idx_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign op_ready = idle && !irq_go;
  assign op_done = (exec && !mem_op && !svc_take && !exc_take) || read_ack;
  assign op_suppressed = priv_trap;
  assign io_start = exec && (op_kind == OP_IO);
  assign irq_ack = irq_ack_q;
  assign irq_ack_index = irq_idx_q;
  assign int_taken = load_ack;
  assign mem_req = !idle;
  assign mem_we = (state_q == ST_STORE_OLD);
  assign mem_addr = addr_q;
  assign mem_wdata = cur;
  assign status_word = cur;
  assign problem_state = is_problem;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_priv_trap: assert property (
    op_ready && op_valid && is_priv && problem_state |-> op_suppressed && !op_done
      ##1 (state_q == ST_STORE_OLD) && (status_word[`IC_HI:`IC_LO] == `XC_PRIV)
  ) else $error("privileged operation in problem state not trapped");

  a_io_privileged: assert property (
    op_ready && op_valid && (op_kind == OP_IO) |-> io_start == !problem_state
  ) else $error("input/output instruction privilege check wrong");

  a_load_whole: assert property (
    read_ack && (kind_q == OP_LOAD_STATUS) |=> status_word == $past(mem_rdata)
      && problem_state == $past(mem_rdata[`PROB_BIT])
  ) else $error("full load did not replace the status word");

  a_branch_state: assert property (
    op_ready && op_valid && (op_kind == OP_BRANCH) |=> $stable(problem_state)
      && $stable(status_word[63:24]) && status_word[23:0] == $past(op_branch_target)
  ) else $error("branch altered more than the address");

  a_svc_vector: assert property (
    (state_q == ST_LOAD_NEW) && (kind_q == OP_SVC) |-> mem_addr == `A_NEW_SVC && !mem_we
  ) else $error("supervisor call fetched the wrong new word");

  a_code_source: assert property (
    $changed(status_word[`IC_HI:`ILC_LO]) |-> $past(upd.ld_code || upd.ld_all)
  ) else $error("interruption code changed without interrupt action");

  a_sys_mask: assert property (
    read_ack && (kind_q == OP_SET_SYS_MASK) |=> status_word[`SM_HI:`SM_LO] ==
      $past(byte_sel(mem_rdata, sel_q)) && $stable(status_word[`IC_HI:`PM_LO])
  ) else $error("system mask not loaded from storage byte");

  a_prog_mask: assert property (
    op_ready && op_valid && (op_kind == OP_SET_PROG_MASK) |=>
      status_word[`CC_HI:`PM_LO] == $past(op_r1_data[29:24]) && $stable(problem_state)
  ) else $error("program mask set wrong");

  a_ovf_cc: assert property (
    exc_ovf |=> status_word[`CC_HI:`CC_LO] == `CC_OVERFLOW
  ) else $error("overflow did not set condition code 3");

  a_masked_quiet: assert property (
    exc_hit && !exc_enabled(op_exc_code, status_word[`PM_HI:`PM_LO]) |-> op_done
      ##1 (state_q == ST_IDLE) && !mem_req
  ) else $error("masked exception caused an interrupt");

  a_irq_taken: assert property (
    idle && |(irq_pend & status_word[`SM_HI:`SM_LO]) |-> !op_ready
      ##1 (state_q == ST_STORE_OLD) && irq_ack
  ) else $error("unmasked request not taken");

  c_priv_trap: cover property (priv_trap);
  c_svc_entry: cover property (svc_take ##[1:20] load_ack);
  c_irq_entry: cover property (irq_go ##[1:20] int_taken);
  c_sys_mask: cover property (read_ack && (kind_q == OP_SET_SYS_MASK));
endmodule

`default_nettype wire

// ### privileged_state_control_tb.sv
// Purpose: Self-checking bench of the supervisor and problem state control.
// Assumes: The bench answers the storage port itself, with a latency set per test.
// Notes: Assertions live in the design files; this bench only drives and compares.
`include "psc_map.svh"
`default_nettype none

module privileged_state_control_tb
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, resetn, op_valid, op_cc_wr, op_exc_valid, mem_ack, problem_state;
  logic op_ready, op_done, op_suppressed, io_start, irq_ack, int_taken, mem_req, mem_we;
  op_kind_e op_kind;
  logic [1:0] op_ilc, op_cc;
  logic [31:0] op_r1_data, op_base_data;
  logic [11:0] op_disp;
  logic [7:0] op_svc_code, irq_pend;
  logic [3:0] op_exc_code;
  logic [2:0] irq_ack_index;
  logic [23:0] op_branch_target, mem_addr, wr_addr, rd_addr;
  logic [63:0] mem_rdata, mem_wdata, status_word, wr_data;
  logic [63:0] mem [logic [23:0]];
  int miscompares, cmp_count, mem_lat, wait_q, done_n, supp_n, io_n, take_n, ack_n;

  priv_state_ctrl dut (
    .mclk(mclk), .resetn(resetn), .op_valid(op_valid), .op_kind(op_kind), .op_ilc(op_ilc),
    .op_r1_data(op_r1_data), .op_base_data(op_base_data), .op_disp(op_disp),
    .op_branch_target(op_branch_target), .op_svc_code(op_svc_code), .op_cc_wr(op_cc_wr),
    .op_cc(op_cc), .op_exc_valid(op_exc_valid), .op_exc_code(op_exc_code),
    .op_ready(op_ready), .op_done(op_done), .op_suppressed(op_suppressed),
    .io_start(io_start), .irq_pend(irq_pend), .irq_ack(irq_ack),
    .irq_ack_index(irq_ack_index), .int_taken(int_taken), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .status_word(status_word), .problem_state(problem_state)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage answer; read data toggles when not answering so stale values never match
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (irq_ack === 1'b1) irq_pend[3'd7 - irq_ack_index] <= 1'b0;
    if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
      if (wait_q < mem_lat) begin
        wait_q <= wait_q + 1;
      end else begin
        wait_q <= 0;
        mem_ack <= 1'b1;
        if (mem_we === 1'b1) begin
          wr_addr <= mem_addr;
          wr_data <= mem_wdata;
        end else begin
          rd_addr <= mem_addr;
          mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 64'h0;
        end
      end
    end
  end

  always @(negedge mclk) begin
    if (op_done === 1'b1) done_n++;
    if (op_suppressed === 1'b1) supp_n++;
    if (io_start === 1'b1) io_n++;
    if (int_taken === 1'b1) take_n++;
    if (irq_ack === 1'b1) ack_n++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Offers one operation, holds it until taken, then waits for idle
  task automatic run_op(input op_kind_e k, input logic [31:0] v, input logic [11:0] disp);
    int n;
    @(posedge mclk);
    n = 0;
    {done_n, supp_n, io_n, take_n, ack_n} = '0;
    op_kind <= k;
    op_r1_data <= v;
    op_base_data <= v;
    op_disp <= disp;
    op_valid <= 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (op_ready !== 1'b1 && n < 300);
    @(posedge mclk);
    op_valid <= 1'b0;
    do begin
      @(negedge mclk);
      n++;
    end while ((op_ready !== 1'b1 || mem_req !== 1'b0) && n < 300);
    if (n >= 300) chk("op finish", 1, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("reset word", 64'h0, status_word);
    chk("reset ready", 1, op_ready);
    $display("test reset done");
  endtask

  task automatic t_set_masks();
    run_op(OP_SET_PROG_MASK, 32'hED00_0000, 12'h0);
    chk("spm word", 64'h0000_0000_2D00_0002, status_word);
    chk("spm done", 1, done_n);
    @(posedge mclk);
    op_ilc <= 2'd2;
    mem_lat = 3;
    run_op(OP_SET_SYS_MASK, 32'hAB00_00F8, 12'h00D);
    chk("ssm read addr", 24'h000100, rd_addr);
    chk("ssm word", 64'h5500_0000_2D00_0006, status_word);
    chk("ssm done", 1, done_n);
    $display("test set masks done");
  endtask

  task automatic t_load_branch();
    @(posedge mclk);
    op_ilc <= 2'd1;
    op_branch_target <= 24'h123456;
    run_op(OP_LOAD_STATUS, 32'h200, 12'h0);
    chk("load word", 64'h0001_0000_2000_0400, status_word);
    chk("load state", 1, problem_state);
    run_op(OP_BRANCH, 32'h0, 12'h0);
    chk("branch word", 64'h0001_0000_2012_3456, status_word);
    $display("test load and branch done");
  endtask

  task automatic t_refuse();
    op_kind_e k [4] = '{OP_LOAD_STATUS, OP_SET_SYS_MASK, OP_IO, OP_PRIV_OTHER};
    for (int i = 0; i < 4; i++) begin
      run_op(k[i], 32'h100, 12'h0);
      chk("suppressed", 1, supp_n);
      chk("no io start", 0, io_n);
      chk("old addr", 24'h000028, wr_addr);
      chk("old code", 16'h0002, wr_data[47:32]);
      chk("old state", 1, wr_data[48]);
      chk("new word", 64'h800, status_word);
      run_op(OP_LOAD_STATUS, 32'h200, 12'h0);
    end
    $display("test refusal done");
  endtask

  task automatic t_svc();
    @(posedge mclk);
    op_svc_code <= 8'h5A;
    mem_lat = 0;
    run_op(OP_SVC, 32'h0, 12'h0);
    chk("svc old addr", 24'h000020, wr_addr);
    chk("svc old code", 16'h005A, wr_data[47:32]);
    chk("svc old ilc", 2'd1, wr_data[31:30]);
    chk("svc new word", 64'hA00, status_word);
    chk("svc state", 0, problem_state);
    run_op(OP_IO, 32'h0, 12'h0);
    chk("io start", 1, io_n);
    $display("test supervisor call done");
  endtask

  task automatic t_exc();
    logic [3:0] code [4] = '{4'h9, 4'hA, 4'hD, 4'hE};
    @(posedge mclk);
    op_cc_wr <= 1'b1;
    op_cc <= 2'h1;
    run_op(OP_GENERAL, 32'h0, 12'h0);
    chk("cc write", 2'h1, status_word[29:28]);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      op_cc_wr <= 1'b0;
      op_exc_valid <= 1'b1;
      op_exc_code <= code[i];
      run_op(OP_SET_PROG_MASK, 32'h0, 12'h0);
      run_op(OP_GENERAL, 32'h0, 12'h0);
      chk("masked trap", 0, take_n);
      if (i < 2) chk("overflow cc", 2'h3, status_word[29:28]);
      run_op(OP_SET_PROG_MASK, 32'h0800_0000 >> i, 12'h0);
      run_op(OP_GENERAL, 32'h0, 12'h0);
      chk("open trap", 1, take_n);
      chk("trap code", {12'h0, code[i]}, wr_data[47:32]);
    end
    @(posedge mclk);
    op_exc_code <= 4'h6;
    run_op(OP_GENERAL, 32'h0, 12'h0);
    chk("unmaskable trap", 1, take_n);
    $display("test exceptions done");
  endtask

  task automatic t_irq();
    @(posedge mclk);
    op_exc_valid <= 1'b0;
    irq_pend <= 8'h41;
    repeat (10) @(negedge mclk);
    chk("held ack", 0, ack_n);
    chk("held ready", 1, op_ready);
    run_op(OP_SET_SYS_MASK, 32'h300, 12'h0);
    chk("io chan", 1, irq_ack_index);
    chk("io ack", 1, ack_n);
    chk("io old addr", 24'h000038, wr_addr);
    chk("io code", 16'h0001, wr_data[47:32]);
    chk("io new word", 64'hC00, status_word);
    run_op(OP_SET_SYS_MASK, 32'h301, 12'h0);
    chk("ext chan", 7, irq_ack_index);
    chk("ext ack", 1, ack_n);
    chk("ext old addr", 24'h000018, wr_addr);
    chk("ext new word", 64'hE00, status_word);
    $display("test pending requests done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, op_valid, op_cc_wr, op_exc_valid, mem_ack} = '0;
    {op_cc, op_r1_data, op_base_data, op_disp, op_branch_target} = '0;
    {op_svc_code, irq_pend, op_exc_code, mem_rdata} = '0;
    op_kind = OP_NONE;
    op_ilc = 2'd1;
    {miscompares, cmp_count, mem_lat, wait_q} = '0;
    mem[24'h000100] = 64'h0011_2233_4455_6677;
    mem[24'h000200] = 64'h0001_0000_2000_0400;
    mem[24'h000300] = 64'h4001_0000_0000_0000;
    mem[24'h000060] = 64'h0000_0000_0000_0A00;
    mem[24'h000068] = 64'h0000_0000_0000_0800;
    mem[24'h000078] = 64'h0000_0000_0000_0C00;
    mem[24'h000058] = 64'h0000_0000_0000_0E00;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_set_masks();
    t_load_branch();
    t_refuse();
    t_svc();
    t_exc();
    t_irq();
    final_report();
  end

  initial begin
    repeat (8000) @(posedge mclk);
    $display("MISMATCH watchdog expected finish seen timeout");
    miscompares++;
    final_report();
  end
endmodule

`default_nettype wire

// ### psc_map.svh
// Purpose: Offsets, field positions, reset values and codes of the status word control.
// Assumes: Bit n of the architected status word (bit 0 leftmost) sits at index 63-n.
// Notes: Storage addresses are byte addresses of 24 bits.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// Status word layout
`define WORD_W 64
`define WORD_RESET 64'h0000_0000_0000_0000
`define SM_HI 63
`define SM_LO 56
`define PROB_BIT 48
`define IC_HI 47
`define IC_LO 32
`define ILC_HI 31
`define ILC_LO 30
`define CC_HI 29
`define CC_LO 28
`define PM_HI 27
`define PM_LO 24
`define IA_HI 23
`define IA_LO 0

// Program mask bit for each maskable exception
`define PM_FIX_OVF 3
`define PM_DEC_OVF 2
`define PM_EXP_UND 1
`define PM_SIGNIF 0

// Program interruption codes and the overflow condition code
`define XC_PRIV 16'h0002
`define XC_FIX_OVF 4'h9
`define XC_DEC_OVF 4'hA
`define XC_EXP_UND 4'hD
`define XC_SIGNIF 4'hE
`define CC_OVERFLOW 2'h3

// Old and new status word locations
`define A_OLD_EXT 24'h000018
`define A_OLD_SVC 24'h000020
`define A_OLD_PROG 24'h000028
`define A_OLD_IO 24'h000038
`define A_NEW_EXT 24'h000058
`define A_NEW_SVC 24'h000060
`define A_NEW_PROG 24'h000068
`define A_NEW_IO 24'h000078

`endif

// ### psc_pkg.sv
// Purpose: Types shared by the status word control.
// Assumes: Nothing beyond the map header.
// Notes: None.
`default_nettype none

package psc_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD_STATUS, OP_SET_SYS_MASK, OP_SET_PROG_MASK,
    OP_BRANCH, OP_IO, OP_SVC, OP_PRIV_OTHER, OP_GENERAL
  } op_kind_e;

  typedef enum logic [1:0] {ST_IDLE, ST_READ_OP, ST_STORE_OLD, ST_LOAD_NEW} seq_state_e;
endpackage

`default_nettype wire

// ### psw_upd_if.sv
// Purpose: Update port between the sequencer and the status word register.
// Assumes: At most one field load of a kind per cycle.
// Notes: A full load overrides every field load.
`include "psc_map.svh"
`default_nettype none

interface word_upd_if;
  logic [`WORD_W-1:0] word;
  logic ld_all;
  logic [`WORD_W-1:0] all_val;
  logic ld_sm;
  logic [7:0] sm_val;
  logic ld_ccpm;
  logic [5:0] ccpm_val;
  logic ld_cc;
  logic [1:0] cc_val;
  logic ld_ia;
  logic [23:0] ia_val;
  logic ld_code;
  logic [15:0] code_val;
  logic [1:0] ilc_val;

  modport ctrl (output ld_all, all_val, ld_sm, sm_val, ld_ccpm, ccpm_val, ld_cc, cc_val,
                ld_ia, ia_val, ld_code, code_val, ilc_val, input word);
  modport store (input ld_all, all_val, ld_sm, sm_val, ld_ccpm, ccpm_val, ld_cc, cc_val,
                 ld_ia, ia_val, ld_code, code_val, ilc_val, output word);
endinterface

`default_nettype wire

// ### status_word_reg.sv
// Purpose: Holds the current status word and applies field updates.
// Assumes: Reset leaves supervisor state with all masks closed.
// Notes: Fields are written only through the update port.
`include "psc_map.svh"
`default_nettype none

module status_word_reg (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Update port
  word_upd_if.store upd
);
  logic [`WORD_W-1:0] word_q;
  logic [`WORD_W-1:0] word_d;

  always_comb begin
    word_d = word_q;
    if (upd.ld_all) begin
      word_d = upd.all_val;
    end else begin
      if (upd.ld_sm) begin
        word_d[`SM_HI:`SM_LO] = upd.sm_val;
      end
      if (upd.ld_code) begin
        word_d[`IC_HI:`IC_LO] = upd.code_val;
        word_d[`ILC_HI:`ILC_LO] = upd.ilc_val;
      end
      if (upd.ld_ccpm) begin
        word_d[`CC_HI:`PM_LO] = upd.ccpm_val;
      end else if (upd.ld_cc) begin
        word_d[`CC_HI:`CC_LO] = upd.cc_val;
      end
      if (upd.ld_ia) begin
        word_d[`IA_HI:`IA_LO] = upd.ia_val;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      word_q <= `WORD_RESET;
    end else begin
      word_q <= word_d;
    end
  end

  assign upd.word = word_q;
endmodule

`default_nettype wire
